// File: pkg/sai_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SAI_DEFINES_SVH
`define SAI_DEFINES_SVH
`define SAI_OFS_ACT01       8'h02
`define SAI_OFS_ACT2        8'h03
`define SAI_OFS_FLAGS       8'h04
`define SAI_OFS_MASK        8'h05
`define SAI_OFS_SELECT      8'h08
`define SAI_MASK_RESET      8'hFF
`define SAI_BIT_SEL_DISRUPT 4
`define SAI_BIT_SEL_SETTLED 5
`define SAI_BIT_FRAME       6
`define SAI_BIT_PADJ        7
`define SAI_CLK_HZ          250000000
`define SAI_LINE_MIN_HZ     1000
`define SAI_FRAME_MIN_HZ    20
`define SAI_LINE_TIMEOUT    (`SAI_CLK_HZ / `SAI_LINE_MIN_HZ)
`define SAI_FRAME_TIMEOUT   (`SAI_CLK_HZ / `SAI_FRAME_MIN_HZ)
`define SAI_TOL             4
`define SAI_CNT_W           24
`endif

// File: pkg/sai_pkg.sv
// Types shared by the sync activity block
package sai_pkg;
    typedef enum logic [1:0] {
        SAI_GREEN_QUIET,
        SAI_GREEN_TOGGLE,
        SAI_GREEN_PERIODIC,
        SAI_GREEN_RSVD
    } sai_green_t;
endpackage : sai_pkg

// File: logic/sai_period_det.sv
// Periodicity detector for one sync input
`timescale 1ns/1ps
`include "sai_defines.svh"
module sai_period_det #(
    parameter logic [23:0] TIMEOUT = 24'h000001
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Synchronised sync level
    input  wire logic        sync_in,
    // Results
    output logic             periodic,
    output logic             toggled,
    output logic             edge_seen
);
    logic [23:0] cnt;
    logic [23:0] last_high;
    logic [23:0] last_low;
    logic        prev;
    logic [1:0]  good;
    logic        quiet_hit;
    logic        consistent;
    wire  logic  edge_now = sync_in ^ prev;
    wire  logic [23:0] ref_len = prev ? last_high : last_low;
    wire  logic [23:0] diff = (cnt > ref_len) ? cnt - ref_len : ref_len - cnt;

    assign quiet_hit  = (cnt >= TIMEOUT);
    assign consistent = (diff <= 24'(`SAI_TOL)) && (ref_len != 24'h000000);
    assign edge_seen  = edge_now;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt       <= 24'h000000;
            last_high <= 24'h000000;
            last_low  <= 24'h000000;
            prev      <= 1'b0;
            good      <= 2'h0;
            periodic  <= 1'b0;
            toggled   <= 1'b0;
        end else begin
            prev <= sync_in;
            if (edge_now) begin
                cnt <= 24'h000001;
                if (prev) begin
                    last_high <= cnt;
                end else begin
                    last_low <= cnt;
                end
                // Two matching phases in a row before claiming periodic
                good     <= consistent ? ((good == 2'h3) ? good : good + 2'h1) : 2'h0;
                periodic <= consistent && (good >= 2'h1);
                toggled  <= 1'b1;
            end else if (quiet_hit) begin
                // Slower than the floor rate counts as silence
                periodic  <= 1'b0;
                toggled   <= 1'b0;
                good      <= 2'h0;
                last_high <= 24'h000000;
                last_low  <= 24'h000000;
            end else begin
                cnt <= cnt + 24'h000001;
            end
        end
    end
endmodule : sai_period_det

// File: logic/sai_sync_irq.sv
// What this block does
// - Line sync reads active only when periodic above 1kHz with steady phases.
// - Frame sync reads active only when periodic above 20Hz with steady phases.
// - Green sync code 00 when slicer output shows no transitions.
// - Green sync code 01 when slicer toggles but not periodically.
// - Green sync code 10 when periodic above 1kHz with steady phases.
// - Channel 0 and 1 in first activity register, channel 2 in second; read only.
// - Flag bits 0..2 set when that channel's activity or polarity changes.
// - Flags stay set until host writes one; zeros leave flags alone.
// - Flag bit 4 set quickly when selected channel line or frame sync changes.
// - Flag bit 5 set when selected channel sync timing settles anew.
// - Flag bit 6 set on every frame sync of the selected input.
// - Flag bit 7 set on phase adjust completion; bit 3 carries nothing.
// - Mask zero lets an event interrupt, one blocks; resets to 0xFF.
// - Unmasked channel bit interrupts on that channel's sync changes.
// - Mask bits 4..7 gate disruption, settled, frame and phase adjust events.
`timescale 1ns/1ps
`include "sai_defines.svh"
module sai_sync_irq (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Sync pins, one bit per channel
    input  wire logic [2:0]  line_sync,
    input  wire logic [2:0]  frame_sync,
    input  wire logic [2:0]  green_embedded_sync,
    // Phase adjuster completion pulse
    input  wire logic        phase_adjust_done_event,
    // Interrupt
    output logic             irq
);
    // Two-stage synchronisers
    logic [8:0] sync_a;
    logic [8:0] sync_b;
    logic       padj_a;
    logic       padj_b;
    logic       padj_d;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= 9'h000;
            sync_b <= 9'h000;
            padj_a <= 1'b0;
            padj_b <= 1'b0;
            padj_d <= 1'b0;
        end else begin
            sync_a <= {green_embedded_sync, frame_sync, line_sync};
            sync_b <= sync_a;
            padj_a <= phase_adjust_done_event;
            padj_b <= padj_a;
            padj_d <= padj_b;
        end
    end

    wire logic [2:0] line_s  = sync_b[2:0];
    wire logic [2:0] frame_s = sync_b[5:3];
    wire logic [2:0] green_s = sync_b[8:6];

    logic [2:0] line_live;
    logic [2:0] frame_live;
    logic [2:0] green_per;
    logic [2:0] green_tog;
    logic [2:0] frame_edge;
    logic [2:0] line_dummy;
    logic [2:0] frame_tog;
    logic [2:0] line_tog;
    logic [2:0] green_edge;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_ch
            sai_period_det #(.TIMEOUT(24'(`SAI_LINE_TIMEOUT))) u_line (
                .hclk      (hclk),
                .hresetn   (hresetn),
                .sync_in   (line_s[gi]),
                .periodic  (line_live[gi]),
                .toggled   (line_tog[gi]),
                .edge_seen (line_dummy[gi])
            );
            sai_period_det #(.TIMEOUT(24'(`SAI_FRAME_TIMEOUT))) u_frame (
                .hclk      (hclk),
                .hresetn   (hresetn),
                .sync_in   (frame_s[gi]),
                .periodic  (frame_live[gi]),
                .toggled   (frame_tog[gi]),
                .edge_seen (frame_edge[gi])
            );
            sai_period_det #(.TIMEOUT(24'(`SAI_LINE_TIMEOUT))) u_green (
                .hclk      (hclk),
                .hresetn   (hresetn),
                .sync_in   (green_s[gi]),
                .periodic  (green_per[gi]),
                .toggled   (green_tog[gi]),
                .edge_seen (green_edge[gi])
            );
        end
    endgenerate

    // Green code per channel
    function automatic logic [1:0] green_code(input logic per, input logic tog);
        if (per) begin
            green_code = sai_pkg::SAI_GREEN_PERIODIC;
        end else if (tog) begin
            green_code = sai_pkg::SAI_GREEN_TOGGLE;
        end else begin
            green_code = sai_pkg::SAI_GREEN_QUIET;
        end
    endfunction : green_code

    wire logic [3:0] chan0_state = {green_code(green_per[0], green_tog[0]),
                                    frame_live[0], line_live[0]};
    wire logic [3:0] chan1_state = {green_code(green_per[1], green_tog[1]),
                                    frame_live[1], line_live[1]};
    wire logic [3:0] chan2_state = {green_code(green_per[2], green_tog[2]),
                                    frame_live[2], line_live[2]};
    wire logic [7:0] act01 = {chan1_state, chan0_state};
    wire logic [7:0] act2  = {4'h0, chan2_state};

    // Polarity: one when the high phase outlasts the low phase
    wire  logic [5:0] pol_in    = {frame_s, line_s};
    wire  logic [5:0] pol_live  = {frame_live, line_live};
    wire  logic [5:0] pol_now;
    wire  logic [2:0] line_pol  = pol_now[2:0];
    wire  logic [2:0] frame_pol = pol_now[5:3];
    logic [3:0] chan0_prev;
    logic [3:0] chan1_prev;
    logic [3:0] chan2_prev;
    logic [2:0] pol_prev;
    logic [2:0] fpol_prev;

    // Selected channel, timing settle tracking
    logic [1:0] select_ch;
    logic [1:0] sel_prev_live;
    logic [1:0] settle_state;
    wire  logic [1:0] sel_idx    = (select_ch == 2'h3) ? 2'h0 : select_ch;
    wire  logic       sel_line   = line_live[sel_idx];
    wire  logic       sel_frame  = frame_live[sel_idx];
    wire  logic       sel_fedge  = frame_edge[sel_idx] & frame_s[sel_idx];
    wire  logic [1:0] sel_live   = {sel_frame, sel_line};
    wire  logic       sel_disrupt = (sel_live != sel_prev_live);
    wire  logic       sel_settled = (settle_state == 2'h1) && (sel_live != 2'h0);

    genvar pj;
    generate
        for (pj = 0; pj < 6; pj = pj + 1) begin : g_pol
            logic [23:0] run;
            logic [23:0] high_len;
            logic        lvl;
            logic        pol;
            wire  logic  rise = pol_in[pj] & ~lvl;
            wire  logic  fall = ~pol_in[pj] & lvl;
            assign pol_now[pj] = pol;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    run      <= 24'h000000;
                    high_len <= 24'h000000;
                    lvl      <= 1'b0;
                    pol      <= 1'b0;
                end else begin
                    lvl <= pol_in[pj];
                    // Saturate so a dead input cannot wrap into a false reading
                    if (rise | fall) begin
                        run <= 24'h000001;
                    end else if (run != 24'hFFFFFF) begin
                        run <= run + 24'h000001;
                    end
                    if (fall) begin
                        high_len <= run;
                    end
                    // Irregular or dead inputs have no polarity to report
                    if (rise && pol_live[pj]) begin
                        pol <= (high_len > run);
                    end
                end
            end
        end
    endgenerate

    // Channel change events
    wire logic [2:0] chan_change = {
        (chan2_state != chan2_prev),
        (chan1_state != chan1_prev),
        (chan0_state != chan0_prev)
    } | ((line_pol ^ pol_prev) | (frame_pol ^ fpol_prev));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan0_prev    <= 4'h0;
            chan1_prev    <= 4'h0;
            chan2_prev    <= 4'h0;
            pol_prev      <= 3'h0;
            fpol_prev     <= 3'h0;
            sel_prev_live <= 2'h0;
            settle_state  <= 2'h0;
        end else begin
            chan0_prev    <= chan0_state;
            chan1_prev    <= chan1_state;
            chan2_prev    <= chan2_state;
            pol_prev      <= line_pol;
            fpol_prev     <= frame_pol;
            sel_prev_live <= sel_live;
            // Disrupt arms; the cycle after it reports settled if line or frame sync is live
            if (sel_disrupt) begin
                settle_state <= 2'h1;
            end else if (settle_state == 2'h1) begin
                settle_state <= 2'h0;
            end
        end
    end

    wire logic [7:0] events = {
        padj_b & ~padj_d,
        sel_fedge,
        sel_settled,
        sel_disrupt,
        1'b0,
        chan_change
    };

    // AHB-Lite address phase capture
    logic        dp_write;
    logic        dp_read;
    logic [7:0]  dp_addr;
    wire  logic  take = hsel & hready & htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= 8'h00;
        end else begin
            dp_write <= take & hwrite;
            dp_read  <= take & ~hwrite;
            dp_addr  <= haddr;
        end
    end

    // One word per register, so the byte address is four times its index
    wire  logic [7:0] adr_act01  = 8'(`SAI_OFS_ACT01 << 2);
    wire  logic [7:0] adr_act2   = 8'(`SAI_OFS_ACT2 << 2);
    wire  logic [7:0] adr_flags  = 8'(`SAI_OFS_FLAGS << 2);
    wire  logic [7:0] adr_mask   = 8'(`SAI_OFS_MASK << 2);
    wire  logic [7:0] adr_select = 8'(`SAI_OFS_SELECT << 2);

    logic [7:0] event_flags;
    logic [7:0] event_mask;
    wire  logic wr_flags = dp_write && (dp_addr == adr_flags);
    wire  logic wr_mask  = dp_write && (dp_addr == adr_mask);
    wire  logic wr_sel   = dp_write && (dp_addr == adr_select);
    wire  logic [7:0] clr_bits = wr_flags ? hwdata[7:0] : 8'h00;
    // Set beats clear when both land together
    wire  logic [7:0] next_flags = (event_flags & ~clr_bits) | events;
    wire  logic [7:0] pending    = event_flags & ~event_mask;
    wire  logic       next_irq   = |(next_flags & ~(wr_mask ? hwdata[7:0] : event_mask));

    wire logic [31:0] rd_mux =
        (haddr == adr_act01)  ? {24'h000000, act01} :
        (haddr == adr_act2)   ? {24'h000000, act2} :
        (haddr == adr_flags)  ? {24'h000000, next_flags} :
        (haddr == adr_mask)   ? {24'h000000, event_mask} :
        (haddr == adr_select) ? {30'h00000000, select_ch} : 32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_flags <= 8'h00;
            event_mask  <= `SAI_MASK_RESET;
            select_ch   <= 2'h0;
            irq         <= 1'b0;
            hrdata      <= 32'h00000000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            event_flags <= next_flags;
            if (wr_mask) begin
                event_mask <= hwdata[7:0];
            end
            if (wr_sel) begin
                select_ch <= hwdata[1:0];
            end
            irq <= next_irq;
            if (take & ~hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Flags: one cycle after an event the bit reads set
    AST_FLAG_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        events[0] |=> event_flags[0]) else $error("ch0 flag missed");
    AST_DISRUPT: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_disrupt |=> event_flags[`SAI_BIT_SEL_DISRUPT]) else $error("disrupt missed");
    AST_SETTLE: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_disrupt ##1 !sel_disrupt && sel_live != 2'h0 |=>
        event_flags[`SAI_BIT_SEL_SETTLED]) else $error("settle missed");
    AST_FRAME: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_fedge |=> event_flags[`SAI_BIT_FRAME]) else $error("frame flag missed");
    AST_PADJ: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(padj_b) |=> event_flags[`SAI_BIT_PADJ]) else $error("padj flag missed");
    AST_BIT3: assert property (@(posedge hclk) disable iff (!hresetn)
        !event_flags[3]) else $error("bit 3 set");
    AST_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
        event_flags[0] && !clr_bits[0] |=> event_flags[0]) else $error("flag lost");
    AST_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_flags && hwdata[1] && !events[1] |=> !event_flags[1]) else $error("no clear");
    AST_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
        irq == (pending != 8'h00)) else $error("irq wrong");
    AST_MASKED: assert property (@(posedge hclk) disable iff (!hresetn)
        (event_mask == 8'hFF) && !wr_mask |=> !irq) else $error("masked irq");
    AST_ACTRO: assert property (@(posedge hclk) disable iff (!hresetn)
        act2[7:4] == 4'h0) else $error("act2 upper bits");
    AST_GREEN: assert property (@(posedge hclk) disable iff (!hresetn)
        !green_tog[0] |-> chan0_state[3:2] == 2'h0) else $error("green code");
    COV_IRQ: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
    COV_LINE: cover property (@(posedge hclk) disable iff (!hresetn) $rose(line_live[0]));
    COV_CLR: cover property (@(posedge hclk) disable iff (!hresetn) wr_flags ##1 !irq);
    COV_PADJ: cover property (@(posedge hclk) disable iff (!hresetn) events[7]);
    COV_POL: cover property (@(posedge hclk) disable iff (!hresetn) $rose(line_pol[0]));
endmodule : sai_sync_irq

// File: dv/sai_sync_source.sv
// Behavioural sync source standing in for the analog video side
`timescale 1ns/1ps
module sai_sync_source (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Two bits per channel: 0 quiet, 1 periodic, 2 irregular, 3 long high phase
    input  wire logic [5:0] chan_mode,
    // Sync pins
    output logic [2:0]      line_sync,
    output logic [2:0]      frame_sync,
    output logic [2:0]      green_embedded_sync
);
    localparam logic [5:0] HALF = 6'h0A;
    // Same period as mode 1, phases within 4 cycles of it, high outlasts low
    localparam logic [5:0] LONG  = 6'h0E;
    localparam logic [5:0] SHORT = 6'h06;
    // No phase lands within 4 cycles of the same-level phase before it
    localparam logic [5:0] IRR [8] = '{6'h05, 6'h09, 6'h14, 6'h21, 6'h0A, 6'h16, 6'h28, 6'h32};
    for (genvar c = 0; c < 3; c++) begin : g_chan
        logic [5:0] cnt;
        logic [2:0] step;
        logic [1:0] fdiv;
        logic       ln;
        logic       fr;
        wire  [1:0] mode = chan_mode[2*c +: 2];
        wire  [5:0] span = (mode == 2'h2) ? IRR[step] :
                           (mode == 2'h3) ? (ln ? LONG : SHORT) : HALF;
        assign line_sync[c]           = ln;
        assign green_embedded_sync[c] = ln;
        assign frame_sync[c]          = fr;
        // Quiet holds every pin still; frame sync runs only when periodic
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                {cnt, step, fdiv, ln, fr} <= '0;
            end else if (mode == 2'h0) begin
                cnt <= '0;
            end else if (cnt >= span - 6'h01) begin
                cnt  <= '0;
                step <= step + 3'h1;
                fdiv <= fdiv + 2'h1;
                ln   <= ~ln;
                if (mode == 2'h1 && fdiv == 2'h3) begin
                    fr <= ~fr;
                end
            end else begin
                cnt <= cnt + 6'h01;
            end
        end
    end
endmodule : sai_sync_source

// File: dv/sai_sync_irq_bench.sv
// Self-checking bench for the sync activity and interrupt block
`timescale 1ns/1ps
`include "sai_defines.svh"
module sai_sync_irq_bench;
    typedef struct packed {
        logic [5:0] mode;
        logic [7:0] idx;
        logic [7:0] exp;
    } sai_row_t;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [2:0]  line_sync;
    logic [2:0]  frame_sync;
    logic [2:0]  green_embedded_sync;
    logic        phase_adjust_done_event;
    logic        irq;
    logic [5:0]  chan_mode;
    logic [31:0] rd;
    int          n_errors;
    int          n_tests;
    sai_row_t    rows [8];

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    sai_sync_irq sai_sync_irq_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .line_sync(line_sync), .frame_sync(frame_sync),
        .green_embedded_sync(green_embedded_sync),
        .phase_adjust_done_event(phase_adjust_done_event), .irq(irq)
    );

    sai_sync_source sai_sync_source_inst (
        .hclk(hclk), .hresetn(hresetn), .chan_mode(chan_mode), .line_sync(line_sync),
        .frame_sync(frame_sync), .green_embedded_sync(green_embedded_sync)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Index times four is the byte address; master never assumes a latency
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= idx << 2;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask : bus

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 32'h0);
        check(rd, {24'h0, exp});
    endtask : rd_chk

    task automatic tally_and_finish;
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // Whole run needs about 4400 cycles
    initial begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        {hresetn, hsel, hwrite, phase_adjust_done_event} = '0;
        haddr     = 8'h00;
        htrans    = 2'h0;
        hsize     = 3'h2;
        hwdata    = 32'h0;
        chan_mode = 6'h00;
        n_errors  = 0;
        n_tests   = 0;
        rows[0] = '{6'h00, `SAI_OFS_ACT01, 8'h00};
        rows[1] = '{6'h00, `SAI_OFS_ACT2, 8'h00};
        rows[2] = '{6'h00, `SAI_OFS_MASK, 8'hFF};
        rows[3] = '{6'h00, `SAI_OFS_FLAGS, 8'h00};
        rows[4] = '{6'h08, `SAI_OFS_ACT01, 8'h40};
        rows[5] = '{6'h18, `SAI_OFS_ACT2, 8'h0B};
        rows[6] = '{6'h19, `SAI_OFS_ACT01, 8'h4B};
        rows[7] = '{6'h19, `SAI_OFS_FLAGS, 8'h77};
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            chan_mode <= rows[i].mode;
            repeat (500) @(posedge hclk);
            rd_chk(rows[i].idx, rows[i].exp);
        end
        check({31'h0, irq}, 32'h0);
        bus(1'b1, `SAI_OFS_MASK, 32'hFE);
        repeat (3) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, `SAI_OFS_FLAGS, 32'h00);
        rd_chk(`SAI_OFS_FLAGS, 8'h77);
        bus(1'b1, `SAI_OFS_FLAGS, 32'h01);
        rd_chk(`SAI_OFS_FLAGS, 8'h76);
        repeat (3) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, `SAI_OFS_MASK, 32'hBF);
        bus(1'b1, `SAI_OFS_FLAGS, 32'h40);
        repeat (200) @(posedge hclk);
        bus(1'b0, `SAI_OFS_FLAGS, 32'h0);
        check(rd & 32'h40, 32'h40);
        check({31'h0, irq}, 32'h1);
        // Frame flag keeps re-arming, so it is left out of the clear-all check
        bus(1'b1, `SAI_OFS_MASK, 32'h7F);
        bus(1'b1, `SAI_OFS_FLAGS, 32'hFF);
        bus(1'b0, `SAI_OFS_FLAGS, 32'h0);
        check(rd & 32'hBF, 32'h0);
        check({31'h0, irq}, 32'h0);
        phase_adjust_done_event <= 1'b1;
        repeat (2) @(posedge hclk);
        phase_adjust_done_event <= 1'b0;
        repeat (8) @(posedge hclk);
        bus(1'b0, `SAI_OFS_FLAGS, 32'h0);
        check(rd & 32'hBF, 32'h80);
        check({31'h0, irq}, 32'h1);
        // Long high phase on channel 0 flips only its line polarity
        bus(1'b1, `SAI_OFS_FLAGS, 32'hFF);
        chan_mode <= 6'h1B;
        repeat (100) @(posedge hclk);
        bus(1'b0, `SAI_OFS_FLAGS, 32'h0);
        check(rd & 32'h37, 32'h01);
        bus(1'b1, `SAI_OFS_ACT01, 32'hFF);
        rd_chk(`SAI_OFS_ACT01, 8'h4B);
        rd_chk(8'h07, 8'h00);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        hresetn <= 1'b1;
        rd_chk(`SAI_OFS_MASK, 8'hFF);
        tally_and_finish();
    end
endmodule : sai_sync_irq_bench
